// *** core/baud_tick.sv ***
// baud_tick: divider giving a one-cycle enable at the oversample rate.
// assumes: DIV of at least 1.
`timescale 1ns/1ps
module baud_tick #(
  parameter int unsigned DIV = 13
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } tick_st_t;

  tick_st_t st_q;
  tick_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.tick = (st_q.cnt == LAST);
    st_d.cnt = st_d.tick ? '0 : st_q.cnt + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;
endmodule : baud_tick

// *** core/bit_sync.sv ***
// bit_sync: two-flop synchroniser for a group of pin levels.
// assumes: pins are asynchronous to clk; reset value is idle high.
`timescale 1ns/1ps
module bit_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_st_t;

  sync_st_t st_q;
  sync_st_t st_d;

  // first stage feeds only the second
  always_comb begin
    st_d = st_q;
    st_d.meta = async_in;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stable;
endmodule : bit_sync

// *** core/uart_mcls_pkg.sv ***
// package: register map, field layouts, states and timing for the
// modem-control / line-status channel.
// assumes: APB with 32-bit data; register index times four is the address.
package uart_mcls_pkg;

  localparam int unsigned ADDR_W = 8;

  // register indices and byte addresses
  localparam logic [ADDR_W-1:0] IDX_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] IDX_MODEM_CONTROL = 8'h04;
  localparam logic [ADDR_W-1:0] IDX_LINE_STATUS = 8'h05;
  localparam logic [ADDR_W-1:0] IDX_MODEM_STATUS = 8'h06;
  localparam logic [ADDR_W-1:0] IDX_CFG = 8'h08;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 8'h09;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 8'h0A;
  localparam logic [ADDR_W-1:0] ADDR_DATA = IDX_DATA << 2;
  localparam logic [ADDR_W-1:0] ADDR_MODEM_CONTROL = IDX_MODEM_CONTROL << 2;
  localparam logic [ADDR_W-1:0] ADDR_LINE_STATUS = IDX_LINE_STATUS << 2;
  localparam logic [ADDR_W-1:0] ADDR_MODEM_STATUS = IDX_MODEM_STATUS << 2;
  localparam logic [ADDR_W-1:0] ADDR_CFG = IDX_CFG << 2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = IDX_IRQ_STATUS << 2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = IDX_IRQ_MASK << 2;

  typedef struct packed {
    logic half_stop;
    logic reserved;
    logic autoflow_enable;
    logic loopback;
    logic aux_output_two;
    logic aux_output_one;
    logic rts;
    logic dtr;
  } modem_control_t;

  typedef struct packed {
    logic rx_fifo_err;
    logic tx_shift_empty;
    logic tx_hold_empty;
    logic brk;
    logic frame;
    logic parity;
    logic overrun;
    logic rx_avail;
  } line_status_t;

  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
    logic [3:0] delta;
  } modem_status_t;

  typedef struct packed {
    logic [4:0] unused;
    logic two_stop;
    logic even;
    logic parity_en;
  } cfg_t;

  typedef struct packed {
    logic [1:0] unused;
    logic brk;
    logic frame;
    logic parity;
    logic overrun;
    logic thr_empty;
    logic rx_avail;
  } events_t;

  typedef struct packed {
    logic rxd;
    logic cts_n;
    logic dsr_n;
    logic ri_n;
    logic dcd_n;
  } modem_in_t;

  typedef struct packed {
    logic txd;
    logic rts_n;
    logic dtr_n;
    logic aux1_n;
    logic aux2_n;
  } modem_out_t;

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_PARITY = 5'b01000,
    TX_STOP = 5'b10000
  } tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA = 5'b00100,
    RX_PARITY = 5'b01000,
    RX_STOP = 5'b10000
  } rx_state_t;

  localparam logic [7:0] MODEM_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

  // oversampling ticks
  localparam logic [5:0] TICKS_BIT = 6'h10;
  localparam logic [5:0] TICKS_HALF = 6'h08;
  localparam logic [5:0] TICKS_TWO = 6'h20;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int unsigned OVERSAMPLE = 16;

endpackage : uart_mcls_pkg

// *** core/uart_mcls_top.sv ***
// uart_mcls_top: one UART channel with modem control and line status,
// reached over APB, with transmitter, receiver and receive FIFO.
// assumes: APB master on clk; modem pins asynchronous, active low.
`timescale 1ns/1ps
//
// Contract
// R1: control bit 0 set drives DTR low
// R2: control bit 1 set drives RTS low
// R3: loopback routes aux output one to ring
// R4: loopback routes aux output two to carrier
// R5: control bit 4 enables internal loopback
// R6: autoflow off: transmitted characters received back
// R7: bits 5,1 select auto RTS and CTS
// R8: control bit 7 gives half stop bit
// R9: status bit 0: receive FIFO not empty
// R10: status bit 1: receive overrun occurred
// R11: status bit 2: received parity error
// R12: status bit 3: framing error, bad stop
// R13: status bit 4: break detected on line
// R14: status bit 5: transmit holding register empty
// R15: status bit 6: transmit shift register empty
// R16: status bit 7: FIFO holds errored character
// R17: modem status shows carrier bit 7, ring 6
// R18: loopback: tx to rx, pins held inactive
module uart_mcls_top #(
  parameter int unsigned CLK_HZ = 25_000_000,
  parameter int unsigned BAUD = 115_200,
  parameter int unsigned RX_DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uart_mcls_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire uart_mcls_pkg::modem_in_t pins_in,
  output uart_mcls_pkg::modem_out_t pins_out,
  output logic irq
);
  localparam int unsigned TICK_DIV =
    CLK_HZ / (BAUD * uart_mcls_pkg::OVERSAMPLE);
  localparam int unsigned PTR_W = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam logic [PTR_W:0] FULL_CNT = (PTR_W + 1)'(RX_DEPTH);

  typedef struct packed {
    uart_mcls_pkg::modem_control_t modem_control;
    uart_mcls_pkg::cfg_t cfg;
    uart_mcls_pkg::events_t ist;
    uart_mcls_pkg::events_t imask;
    logic [31:0] prdata;
    logic slverr;
    logic [7:0] thr;
    logic thr_full;
    uart_mcls_pkg::tx_state_t tst;
    logic [5:0] tcnt;
    logic [2:0] tbit;
    logic [7:0] tsr;
    logic tpar;
    logic txd;
    uart_mcls_pkg::rx_state_t rst;
    logic [5:0] rcnt;
    logic [2:0] rbit;
    logic [7:0] rsr;
    logic rpar;
    logic [RX_DEPTH-1:0][10:0] fifo;
    logic [PTR_W-1:0] wp;
    logic [PTR_W-1:0] rp;
    logic [PTR_W:0] cnt;
    logic overrun;
    logic perr;
    logic ferr;
    logic brk;
  } state_t;

  state_t q;
  state_t d;
  uart_mcls_pkg::modem_in_t pin_s;
  logic tick;

  bit_sync #(.W($bits(uart_mcls_pkg::modem_in_t))) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(pins_in),
    .sync_out(pin_s)
  );

  baud_tick #(.DIV((TICK_DIV > 0) ? TICK_DIV : 1)) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  logic loop;
  logic auto_cts;
  logic auto_rts;
  logic cts_on;
  logic fifo_full;
  logic rx_line;
  logic [5:0] tlen;
  logic tend;
  logic rend;
  logic push;
  logic pop;
  logic fifo_err;
  logic [PTR_W-1:0] off;
  logic [10:0] entry;
  logic rx_perr;
  logic rx_ferr;
  logic rx_brk;
  uart_mcls_pkg::events_t ev;
  uart_mcls_pkg::line_status_t line_status;
  uart_mcls_pkg::modem_status_t msr;

  always_comb begin
    d = q;
    ev = '0;
    push = 1'b0;
    pop = 1'b0;
    rx_perr = 1'b0;
    rx_ferr = 1'b0;
    rx_brk = 1'b0;
    entry = '0;
    off = '0;
    loop = q.modem_control.loopback; // [R5]
    auto_cts = q.modem_control.autoflow_enable; // [R7]
    auto_rts = q.modem_control.autoflow_enable & q.modem_control.rts; // [R7]
    cts_on = loop ? q.modem_control.rts : ~pin_s.cts_n;
    fifo_full = (q.cnt == FULL_CNT);
    // diagnostic mode and loopback both hear our own line
    rx_line = (loop | ~q.modem_control.autoflow_enable) ? q.txd : pin_s.rxd; // [R6] [R18]

    // error summary over valid fifo entries
    fifo_err = 1'b0;
    for (int i = 0; i < RX_DEPTH; i++) begin
      off = PTR_W'(i) - q.rp;
      if (({1'b0, off} < q.cnt) && (|q.fifo[i][10:8])) begin
        fifo_err = 1'b1; // [R16]
      end
    end

    line_status.rx_avail = (q.cnt != '0); // [R9]
    line_status.overrun = q.overrun; // [R10]
    line_status.parity = q.perr; // [R11]
    line_status.frame = q.ferr; // [R12]
    line_status.brk = q.brk; // [R13]
    line_status.tx_hold_empty = ~q.thr_full; // [R14]
    line_status.tx_shift_empty = (q.tst == uart_mcls_pkg::TX_IDLE); // [R15]
    line_status.rx_fifo_err = fifo_err; // [R16]

    msr.dcd = loop ? q.modem_control.aux_output_two : ~pin_s.dcd_n; // [R4] [R17]
    msr.ri = loop ? q.modem_control.aux_output_one : ~pin_s.ri_n; // [R3] [R17]
    msr.dsr = loop ? q.modem_control.dtr : ~pin_s.dsr_n;
    msr.cts = cts_on;
    msr.delta = '0;

    // setup phase: latch read data so it comes from a flop
    if (psel && !penable) begin
      d.slverr = 1'b0;
      d.prdata = '0;
      if (paddr == uart_mcls_pkg::ADDR_DATA) begin
        d.prdata[7:0] = q.fifo[q.rp][7:0];
      end else if (paddr == uart_mcls_pkg::ADDR_MODEM_CONTROL) begin
        d.prdata[7:0] = q.modem_control;
      end else if (paddr == uart_mcls_pkg::ADDR_LINE_STATUS) begin
        d.prdata[7:0] = line_status;
      end else if (paddr == uart_mcls_pkg::ADDR_MODEM_STATUS) begin
        d.prdata[7:0] = msr;
      end else if (paddr == uart_mcls_pkg::ADDR_CFG) begin
        d.prdata[7:0] = q.cfg;
      end else if (paddr == uart_mcls_pkg::ADDR_IRQ_STATUS) begin
        d.prdata[7:0] = q.ist;
      end else if (paddr == uart_mcls_pkg::ADDR_IRQ_MASK) begin
        d.prdata[7:0] = q.imask;
      end else begin
        d.slverr = 1'b1;
      end
    end

    // access phase: effects of writes and reads
    if (psel && penable) begin
      if (pwrite) begin
        if (paddr == uart_mcls_pkg::ADDR_DATA) begin
          d.thr = pwdata[7:0];
          d.thr_full = 1'b1;
        end else if (paddr == uart_mcls_pkg::ADDR_MODEM_CONTROL) begin
          d.modem_control = pwdata[7:0];
          d.modem_control.reserved = 1'b0;
        end else if (paddr == uart_mcls_pkg::ADDR_CFG) begin
          d.cfg = pwdata[7:0];
          d.cfg.unused = '0;
        end else if (paddr == uart_mcls_pkg::ADDR_IRQ_STATUS) begin
          d.ist = q.ist & ~pwdata[7:0];
        end else if (paddr == uart_mcls_pkg::ADDR_IRQ_MASK) begin
          d.imask = pwdata[7:0];
        end
      end else begin
        if (paddr == uart_mcls_pkg::ADDR_DATA) begin
          pop = (q.cnt != '0);
        end else if (paddr == uart_mcls_pkg::ADDR_LINE_STATUS) begin
          // read clears the sticky errors; a new error below still lands
          d.overrun = 1'b0;
          d.perr = 1'b0;
          d.ferr = 1'b0;
          d.brk = 1'b0;
        end
      end
    end

    // transmitter
    tlen = uart_mcls_pkg::TICKS_BIT;
    if (q.tst == uart_mcls_pkg::TX_STOP) begin
      if (q.modem_control.half_stop) begin
        tlen = uart_mcls_pkg::TICKS_HALF; // [R8]
      end else if (q.cfg.two_stop) begin
        tlen = uart_mcls_pkg::TICKS_TWO; // [R8]
      end
    end
    tend = tick && (q.tcnt == tlen - 6'h01);
    if (tick && q.tst != uart_mcls_pkg::TX_IDLE) begin
      d.tcnt = tend ? 6'h00 : q.tcnt + 6'h01;
    end
    case (q.tst)
      uart_mcls_pkg::TX_IDLE: begin
        d.txd = 1'b1;
        // auto-CTS holds a new character while the peer is not ready
        if (q.thr_full && (!auto_cts || cts_on)) begin // [R7]
          d.tsr = q.thr;
          d.tpar = (^q.thr) ^ ~q.cfg.even;
          d.thr_full = 1'b0;
          ev.thr_empty = 1'b1;
          d.tcnt = 6'h00;
          d.txd = 1'b0;
          d.tst = uart_mcls_pkg::TX_START;
        end
      end
      uart_mcls_pkg::TX_START: begin
        if (tend) begin
          d.tbit = '0;
          d.txd = q.tsr[0];
          d.tst = uart_mcls_pkg::TX_DATA;
        end
      end
      uart_mcls_pkg::TX_DATA: begin
        if (tend) begin
          d.tsr = {1'b0, q.tsr[7:1]};
          d.tbit = q.tbit + 3'h1;
          d.txd = q.tsr[1];
          if (q.tbit == uart_mcls_pkg::LAST_BIT) begin
            d.txd = q.cfg.parity_en ? q.tpar : 1'b1;
            d.tst = q.cfg.parity_en ? uart_mcls_pkg::TX_PARITY
                                    : uart_mcls_pkg::TX_STOP;
          end
        end
      end
      uart_mcls_pkg::TX_PARITY: begin
        if (tend) begin
          d.txd = 1'b1;
          d.tst = uart_mcls_pkg::TX_STOP;
        end
      end
      uart_mcls_pkg::TX_STOP: begin
        if (tend) begin
          d.tst = uart_mcls_pkg::TX_IDLE;
        end
      end
      default: begin
        d.tst = uart_mcls_pkg::TX_IDLE;
      end
    endcase

    // receiver: samples mid-bit, a start half bit then whole bits
    rend = tick && (q.rcnt == uart_mcls_pkg::TICKS_BIT - 6'h01);
    if (tick && q.rst != uart_mcls_pkg::RX_IDLE) begin
      d.rcnt = rend ? 6'h00 : q.rcnt + 6'h01;
    end
    case (q.rst)
      uart_mcls_pkg::RX_IDLE: begin
        if (tick && !rx_line) begin
          d.rcnt = 6'h00;
          d.rst = uart_mcls_pkg::RX_START;
        end
      end
      uart_mcls_pkg::RX_START: begin
        if (tick && q.rcnt == uart_mcls_pkg::TICKS_HALF - 6'h01) begin
          d.rcnt = 6'h00;
          d.rbit = '0;
          // a high line at mid start was a glitch
          d.rst = rx_line ? uart_mcls_pkg::RX_IDLE : uart_mcls_pkg::RX_DATA;
        end
      end
      uart_mcls_pkg::RX_DATA: begin
        if (rend) begin
          d.rsr = {rx_line, q.rsr[7:1]};
          d.rbit = q.rbit + 3'h1;
          if (q.rbit == uart_mcls_pkg::LAST_BIT) begin
            d.rpar = 1'b0;
            d.rst = q.cfg.parity_en ? uart_mcls_pkg::RX_PARITY
                                    : uart_mcls_pkg::RX_STOP;
          end
        end
      end
      uart_mcls_pkg::RX_PARITY: begin
        if (rend) begin
          d.rpar = rx_line;
          d.rst = uart_mcls_pkg::RX_STOP;
        end
      end
      uart_mcls_pkg::RX_STOP: begin
        if (rend) begin
          rx_ferr = ~rx_line; // [R12]
          rx_perr = q.cfg.parity_en &
                    (q.rpar != ((^q.rsr) ^ ~q.cfg.even)); // [R11]
          rx_brk = ~rx_line && (q.rsr == 8'h00) && !q.rpar; // [R13]
          entry = {rx_brk, rx_ferr, rx_perr, q.rsr};
          push = 1'b1;
          d.rst = uart_mcls_pkg::RX_IDLE;
        end
      end
      default: begin
        d.rst = uart_mcls_pkg::RX_IDLE;
      end
    endcase

    // fifo; a pop in the same cycle makes room for the push
    if (push) begin
      if (fifo_full && !pop) begin
        d.overrun = 1'b1; // [R10]
        ev.overrun = 1'b1;
        push = 1'b0;
      end else begin
        d.fifo[q.wp] = entry;
        d.wp = q.wp + 1'b1;
        ev.rx_avail = 1'b1;
      end
      if (rx_perr) begin
        d.perr = 1'b1;
      end
      if (rx_ferr) begin
        d.ferr = 1'b1;
      end
      if (rx_brk) begin
        d.brk = 1'b1;
      end
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};

    ev.parity = rx_perr;
    ev.frame = rx_ferr;
    ev.brk = rx_brk;
    // set wins over a same-cycle clear
    d.ist = d.ist | ev;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.modem_control <= uart_mcls_pkg::MODEM_CONTROL_RESET; // [R1] [R2] [R5]
      q.cfg <= uart_mcls_pkg::CFG_RESET;
      q.imask <= uart_mcls_pkg::IRQ_MASK_RESET;
      q.tst <= uart_mcls_pkg::TX_IDLE;
      q.rst <= uart_mcls_pkg::RX_IDLE;
      q.txd <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = psel & penable;
  assign pslverr = psel & penable & q.slverr;
  assign irq = |(q.ist & q.imask);

  // loopback keeps every modem output at its idle level
  assign pins_out.txd = loop | q.txd; // [R18]
  assign pins_out.dtr_n = loop | ~q.modem_control.dtr; // [R1] [R18]
  assign pins_out.rts_n = loop | (auto_rts ? fifo_full : ~q.modem_control.rts); // [R2]
  assign pins_out.aux1_n = loop | ~q.modem_control.aux_output_one; // [R18]
  assign pins_out.aux2_n = loop | ~q.modem_control.aux_output_two; // [R18]
endmodule : uart_mcls_top

// *** dv/uart_mcls_peer.sv ***
// peer model: far-side uart and modem lines, idle at mark.
// assumes: one bit lasts BIT clocks; 8 data bits, lsb first.
`timescale 1ns/1ps
module uart_mcls_peer #(
  parameter int unsigned BIT = 16
) (
  input wire logic clk,
  input wire logic txd,
  output uart_mcls_pkg::modem_in_t pins
);
  logic rxd_q = 1'b1;
  logic [3:0] lines_q = 4'hF;
  assign pins = {rxd_q, lines_q};
  task automatic set_lines(input logic [3:0] v);
    @(posedge clk);
    lines_q <= v;
  endtask : set_lines
  // ignores rts on purpose so the receive fifo can be overrun
  task automatic send(input logic [8:0] d, input logic par,
                      input logic stop);
    @(posedge clk);
    rxd_q <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      if (i < 8 || par) begin
        rxd_q <= d[i];
        repeat (BIT) @(posedge clk);
      end
    end
    rxd_q <= stop;
    repeat (BIT) @(posedge clk);
    rxd_q <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask : send
  task automatic recv(output logic [7:0] d);
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      d[i] = txd;
    end
  endtask : recv
endmodule : uart_mcls_peer

// *** dv/uart_mcls_props.sv ***
// checker: apb answer, control pins, loopback lines, interrupt mask.
// assumes: bound to uart_mcls_top; one clock, async active-low reset.
`timescale 1ns/1ps
module uart_mcls_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uart_mcls_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire uart_mcls_pkg::modem_in_t pins_in,
  input wire uart_mcls_pkg::modem_out_t pins_out,
  input wire logic irq
);
  localparam logic [7:0] MC = uart_mcls_pkg::ADDR_MODEM_CONTROL;
  localparam logic [7:0] MS = uart_mcls_pkg::ADDR_MODEM_STATUS;
  localparam logic [7:0] IMK = uart_mcls_pkg::ADDR_IRQ_MASK;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic acc;
  logic wr_mc;
  logic [7:0] mc_q;
  assign acc = psel && penable;
  assign wr_mc = acc && pwrite && paddr == MC;
  // mirror of the control register; bit 6 always reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mc_q <= 8'h00;
    end else if (wr_mc) begin
      mc_q <= pwdata[7:0] & 8'hBF;
    end
  end
  a_zero_wait: assert property (acc |-> pready)
    else $error("access phase without ready");
  a_bad_addr: assert property (acc && paddr == 8'h3C |-> pslverr)
    else $error("unmapped address not refused");
  // two cycles allow for one extra output register
  a_dtr_level: assert property (
    wr_mc && !pwdata[4] |-> ##2 pins_out.dtr_n == !$past(pwdata[0], 2))
    else $error("dtr pin does not follow control");
  a_rts_level: assert property (
    wr_mc && pwdata[5:4] == 2'b00 |-> ##2
    pins_out.rts_n == !$past(pwdata[1], 2))
    else $error("rts pin does not follow control");
  a_loop_quiet: assert property (
    wr_mc && pwdata[4] |-> ##2 pins_out == 5'h1F)
    else $error("pins active in loopback");
  a_ctrl_read: assert property (
    acc && !pwrite && paddr == MC |-> prdata[7:0] == mc_q)
    else $error("control read differs from written");
  a_loop_aux: assert property (
    acc && !pwrite && paddr == MS && mc_q[4] |-> prdata[7:6] == mc_q[3:2])
    else $error("aux outputs not looped to lines");
  a_irq_masked: assert property (
    acc && pwrite && paddr == IMK && pwdata[7:0] == 8'h00 |-> ##2 !irq)
    else $error("irq high with all masked");
  c_loop_read: cover property (acc && paddr == MS && mc_q[4]);
  c_irq_rise: cover property ($rose(irq));
  c_refused: cover property (acc && pslverr);
endmodule : uart_mcls_props
bind uart_mcls_top uart_mcls_props u_props (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pins_in(pins_in), .pins_out(pins_out), .irq(irq));

// *** dv/uart_mcls_top_tb.sv ***
// testbench: apb register tasks plus peer model, self checking.
// assumes: baud set for one tick a clock, so a bit is 16 clocks.
`timescale 1ns/1ps
module uart_mcls_top_tb;
  localparam int unsigned BIT = 16;
  localparam int TMAX = 30000;
  localparam logic [7:0] MC = uart_mcls_pkg::ADDR_MODEM_CONTROL;
  localparam logic [7:0] LS = uart_mcls_pkg::ADDR_LINE_STATUS;
  localparam logic [7:0] MS = uart_mcls_pkg::ADDR_MODEM_STATUS;
  localparam logic [7:0] DAT = uart_mcls_pkg::ADDR_DATA;
  localparam logic [7:0] CFG = uart_mcls_pkg::ADDR_CFG;
  localparam logic [7:0] IST = uart_mcls_pkg::ADDR_IRQ_STATUS;
  localparam logic [7:0] IMK = uart_mcls_pkg::ADDR_IRQ_MASK;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  uart_mcls_pkg::modem_in_t pins_in;
  uart_mcls_pkg::modem_out_t pins_out;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] r;
  logic e;
  logic [7:0] b;
  always #20 clk = ~clk;
  uart_mcls_top #(.CLK_HZ(25_000_000), .BAUD(1_562_500), .RX_DEPTH(4)) dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins_in(pins_in),
    .pins_out(pins_out), .irq(irq));
  uart_mcls_peer #(.BIT(BIT)) peer (.clk(clk), .txd(pins_out.txd),
    .pins(pins_in));
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] x);
    compares++;
    if (s !== x) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // waits for pready; never assumes the zero-wait answer
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // pready ends this wait; if it never rises, only the cycle ceiling does
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic t_reset;
    rd(MC);
    chk("control reset", r, 32'h0);
    rd(LS);
    chk("status reset", r, 32'h60);
    chk("pins reset", 32'(pins_out), 32'h1F);
    rd(8'h3C);
    chk("unmapped err", 32'(e), 32'h1);
  endtask : t_reset
  task automatic t_pins;
    for (int i = 0; i < 4; i++) begin
      wr(MC, 32'(i) | 32'h40);
      repeat (2) @(posedge clk);
      chk("dtr pin", 32'(pins_out.dtr_n), 32'(!i[0]));
      chk("rts pin", 32'(pins_out.rts_n), 32'(!i[1]));
      rd(MC);
      chk("control read", r, 32'(i));
    end
  endtask : t_pins
  task automatic t_loop;
    for (int i = 0; i < 4; i++) begin
      wr(MC, 32'h13 | 32'(i << 2));
      rd(MS);
      chk("looped lines", 32'(r[7:4]), 32'({i[1], i[0], 2'b11}));
      chk("pins quiet", 32'(pins_out), 32'h1F);
    end
    wr(MC, 32'h00);
  endtask : t_loop
  task automatic t_echo_irq;
    wr(IMK, 32'h02);
    wr(DAT, 32'hA5);
    rd(LS);
    chk("shift busy", 32'(r[6]), 32'h0);
    chk("irq raised", 32'(irq), 32'h1);
    wr(IMK, 32'h00);
    repeat (2) @(posedge clk);
    chk("irq masked", 32'(irq), 32'h0);
    wr(IMK, 32'h02);
    repeat (2) @(posedge clk);
    chk("irq again", 32'(irq), 32'h1);
    wr(IST, 32'h02);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'(irq), 32'h0);
    repeat (BIT * 12) @(posedge clk);
    rd(LS);
    chk("echo status", r, 32'h61);
    rd(DAT);
    chk("echo byte", r, 32'hA5);
    rd(LS);
    chk("fifo empty", 32'(r[0]), 32'h0);
  endtask : t_echo_irq
  task automatic rx_flag(input logic [8:0] d, input logic stop, input int k);
    peer.send(d, 1'b1, stop);
    rd(LS);
    chk("error flag", 32'(r[k]), 32'h1);
    chk("fifo error", 32'(r[7]), 32'h1);
    rd(DAT);
    chk("errored byte", r, 32'(d[7:0]));
    rd(LS);
    chk("flags clear", r & 32'h9F, 32'h0);
  endtask : rx_flag
  task automatic t_errors;
    wr(MC, 32'h20);
    wr(CFG, 32'h01);
    rx_flag(9'h101, 1'b1, 2);
    rx_flag(9'h155, 1'b0, 3);
    rx_flag(9'h000, 1'b0, 4);
    wr(CFG, 32'h00);
  endtask : t_errors
  task automatic t_flow;
    wr(MC, 32'h22);
    wr(DAT, 32'h3C);
    repeat (BIT * 2) @(posedge clk);
    chk("held by cts", 32'(pins_out.txd), 32'h1);
    rd(LS);
    chk("holding full", 32'(r[5]), 32'h0);
    peer.set_lines(4'h6);
    peer.recv(b);
    chk("sent byte", 32'(b), 32'h3C);
    rd(MS);
    chk("modem lines", r, 32'h90);
    for (int i = 0; i < 5; i++) begin
      peer.send(9'(i + 16), 1'b0, 1'b1);
      if (i > 1 && i < 4) begin
        chk("auto rts", 32'(pins_out.rts_n), 32'(i == 3));
      end
    end
    rd(LS);
    chk("overrun", 32'(r[1:0]), 32'h3);
    rd(DAT);
    chk("oldest kept", r, 32'h10);
    wr(MC, 32'h20);
    repeat (2) @(posedge clk);
    chk("cts only", 32'(pins_out.rts_n), 32'h1);
    repeat (3) rd(DAT);
  endtask : t_flow
  task automatic t_stop_gap;
    int n;
    logic [31:0] x;
    for (int m = 0; m < 3; m++) begin
      wr(MC, (m == 1) ? 32'h80 : 32'h00);
      wr(CFG, (m == 2) ? 32'h04 : 32'h00);
      wr(DAT, 32'h00);
      wr(DAT, 32'h00);
      n = 0;
      while (pins_out.txd !== 1'b1) @(posedge clk);
      while (pins_out.txd === 1'b1 && n < 40) begin
        @(posedge clk);
        n++;
      end
      // plus one clock: the shifter reloads only after the stop ends
      x = (m == 1) ? 32'h09 : ((m == 2) ? 32'h21 : 32'h11);
      chk("stop length", 32'(n), x);
      repeat (BIT * 12) @(posedge clk);
    end
  endtask : t_stop_gap
  task automatic end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  // hang guard: a run out of cycles counts as a mismatch
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == TMAX) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_pins();
    t_loop();
    t_echo_irq();
    t_errors();
    t_flow();
    t_stop_gap();
    end_of_test();
  end
endmodule : uart_mcls_top_tb
